/* File: core/scrc_map.svh */
// register offsets, reset values, multiplier limits and timing counts
`ifndef SCRC_MAP_SVH
`define SCRC_MAP_SVH
`define SCRC_OFF_CFG   8'h00
`define SCRC_OFF_LBR   8'h04
`define SCRC_OFF_STAT  8'h08
`define SCRC_OFF_CEC   8'h0C
`define SCRC_OFF_CORE  8'h10
`define SCRC_OFF_PIN   8'h14
`define SCRC_LBR_RST   2'h0
`define SCRC_CEM_RST   4'h6
`define SCRC_CED_RST   1'b0
`define SCRC_CORE_RST  7'h04
`define SCRC_PIN_RST   8'h00
`define SCRC_MULT_MIN  4'h2
`define SCRC_MULT_MAX  4'h6
`define SCRC_SAMPLE_CYC 2'h3
`endif

/* File: core/scrc_pkg.sv */
// types of the clock ratio configuration block
package scrc_pkg;
    typedef struct packed {
        logic       host_is_agent;
        logic       in_div;
        logic       mem_mode;
        logic       lb_mode;
        logic [3:0] mult;
    } scrc_strap_t;
    typedef enum logic [1:0] {
        SCRC_S_WAIT = 2'h0,
        SCRC_S_SYS  = 2'h1,
        SCRC_S_CORE = 2'h3,
        SCRC_S_RUN  = 2'h2
    } scrc_state_t;
    typedef enum logic [1:0] {
        SCRC_LB_DIV2 = 2'h0,
        SCRC_LB_DIV4 = 2'h1,
        SCRC_LB_DIV8 = 2'h2
    } scrc_lbdiv_t;
endpackage : scrc_pkg

/* File: core/scrc_top.sv */
// clock source select, ratio configuration and bring-up sequencing
`include "scrc_map.svh"

// Overview of operation
// R1: bus agent takes peripheral bus clock as source, host takes oscillator input.
// R2: multiplier codes 2 to 6 select times 2 to 6; others reserved.
// R3: input to system bus ratio follows both clock modes, multiplier, divide strap.
// R4: local bus output clock is base clock over 2, 4 or 8.
// R5: local bus base clock is once or twice the system bus clock.
// R6: memory interface moves data on both edges, twice its clock rate.
// R7: software keeps the system PLL VCO between 300 and 600 MHz.
// R8: core PLL follows system PLL and uses system bus clock as reference.
// R9: comms engine PLL is configured apart, sharing only the input clock.
// R10: memory bus clock is configured no faster than 133 MHz.
// R11: local bus output clock is configured no faster than 66 MHz.
// R12: primary input clock must not exceed 66 MHz.
// R13: input, multiplier and core setting keep all clocks inside limits.
// R14: strap pins are sampled at power-on, then act as outputs.
// R15: derived clocks stay gated until feeding PLLs report lock.
module scrc_top (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // apb slave
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // strap pins
    input  wire scrc_pkg::scrc_strap_t strap_pin_in,
    output logic      [7:0]           strap_pin_out,
    output logic                      strap_pin_oe,
    // pll control
    input  wire logic                 sys_pll_lock,
    input  wire logic                 core_pll_lock,
    input  wire logic                 ce_pll_lock,
    output logic                      src_is_bus_clk,
    output logic      [3:0]           sys_pll_mult,
    output logic                      sys_pll_rst_n,
    output logic      [6:0]           core_pll_setting,
    output logic                      core_pll_rst_n,
    output logic      [3:0]           comms_engine_pll_mult,
    output logic                      comms_engine_pll_div,
    output logic                      ce_pll_rst_n,
    // derived clocks
    output logic                      local_bus_base_en,
    output logic                      local_bus_output_clock,
    output logic                      mem_clk,
    output logic                      mem_beat,
    output logic                      cfg_error
);
    import scrc_pkg::*;

    // ----------------------------------------
    // assertion clocking
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_reg <= 11'h000;
            sync2_reg <= 11'h000;
        end else begin
            sync1_reg <= {ce_pll_lock, core_pll_lock, sys_pll_lock, strap_pin_in};
            sync2_reg <= sync1_reg;
        end
    end
    scrc_strap_t strap_s;
    wire         sys_lock_s  = sync2_reg[8];
    wire         core_lock_s = sync2_reg[9];
    wire         ce_lock_s   = sync2_reg[10];
    assign strap_s = scrc_strap_t'(sync2_reg[7:0]);

    // ----------------------------------------
    // bring-up sequence
    // ----------------------------------------
    scrc_state_t st_reg;
    scrc_state_t st_next;
    logic [1:0]  wait_reg;
    scrc_strap_t cfg_reg;
    logic        taken_reg;
    wire mult_ok = (strap_s.mult >= `SCRC_MULT_MIN) && (strap_s.mult <= `SCRC_MULT_MAX);
    wire capture = (st_reg == SCRC_S_WAIT) && (wait_reg == `SCRC_SAMPLE_CYC) && !taken_reg;
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            SCRC_S_WAIT: if (capture && mult_ok) st_next = SCRC_S_SYS;
            SCRC_S_SYS:  if (sys_lock_s) st_next = SCRC_S_CORE;
            SCRC_S_CORE: if (core_lock_s) st_next = SCRC_S_RUN;
            SCRC_S_RUN:  if (!sys_lock_s) st_next = SCRC_S_SYS;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg   <= SCRC_S_WAIT;
            wait_reg <= 2'h0;
            cfg_reg  <= scrc_strap_t'(8'h00);
            taken_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (st_reg == SCRC_S_WAIT && wait_reg != `SCRC_SAMPLE_CYC)
                wait_reg <= wait_reg + 2'h1;
            if (capture) begin
                cfg_reg   <= strap_s; // see R14
                taken_reg <= 1'b1; // see R14
            end
        end
    end
    wire sampled = taken_reg;
    wire running = (st_reg == SCRC_S_RUN) && sys_lock_s && core_lock_s;

    // ----------------------------------------
    // bring-up checks
    // ----------------------------------------
    chk_cfg_frozen: assert property (taken_reg |=> $stable(cfg_reg)) // see R14
        else $error("strap configuration changed after capture");
    chk_one_capture: assert property (capture |=> !capture) // see R14
        else $error("straps captured twice");
    chk_run_locks: assert property ($rose(st_reg == SCRC_S_RUN) |-> $past(core_lock_s)) // see R15
        else $error("run state entered without core lock");

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    logic [1:0] lbr_reg;
    logic [3:0] cem_reg;
    logic       ced_reg;
    logic [6:0] core_reg;
    logic [7:0] pin_reg;
    logic       done_reg;
    wire acc   = psel && penable && !pready;
    wire wr_ok = psel && penable && pready && pwrite;
    wire hit_cfg  = paddr == `SCRC_OFF_CFG;
    wire hit_lbr  = paddr == `SCRC_OFF_LBR;
    wire hit_stat = paddr == `SCRC_OFF_STAT;
    wire hit_cec  = paddr == `SCRC_OFF_CEC;
    wire hit_core = paddr == `SCRC_OFF_CORE;
    wire hit_pin  = paddr == `SCRC_OFF_PIN;
    wire mapped = hit_cfg | hit_lbr | hit_stat | hit_cec | hit_core | hit_pin;
    wire [1:0] den_sh = 2'({1'b0, cfg_reg.in_div} + {1'b0, cfg_reg.lb_mode}
                          + {1'b0, cfg_reg.mem_mode}); // see R3
    wire [3:0] ratio_den = 4'h1 << den_sh;
    wire [31:0] stat_val = {16'h0000, ratio_den, cfg_reg.mult, 1'b0, st_reg,
                            cfg_error, ce_lock_s, core_lock_s, sys_lock_s, done_reg};
    wire [31:0] rd_val = hit_cfg  ? {24'h000000, cfg_reg} :
                         hit_lbr  ? {30'h0, lbr_reg} :
                         hit_stat ? stat_val :
                         hit_cec  ? {27'h0, ced_reg, cem_reg} :
                         hit_core ? {25'h0, core_reg} :
                         hit_pin  ? {24'h000000, pin_reg} : 32'h00000000;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            prdata  <= acc && !pwrite ? rd_val : 32'h00000000;
            pslverr <= acc && !mapped;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lbr_reg  <= `SCRC_LBR_RST;
            cem_reg  <= `SCRC_CEM_RST;
            ced_reg  <= `SCRC_CED_RST;
            core_reg <= `SCRC_CORE_RST;
            pin_reg  <= `SCRC_PIN_RST;
        end else if (wr_ok) begin
            if (hit_lbr)  lbr_reg  <= pwdata[1:0];
            if (hit_cec)  cem_reg  <= pwdata[3:0]; // see R9
            if (hit_cec)  ced_reg  <= pwdata[4];
            if (hit_core) core_reg <= pwdata[6:0];
            if (hit_pin)  pin_reg  <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // pll and pin outputs
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            src_is_bus_clk        <= 1'b0;
            sys_pll_mult          <= 4'h0;
            sys_pll_rst_n         <= 1'b0;
            core_pll_setting      <= `SCRC_CORE_RST;
            core_pll_rst_n        <= 1'b0;
            comms_engine_pll_mult <= `SCRC_CEM_RST;
            comms_engine_pll_div  <= `SCRC_CED_RST;
            ce_pll_rst_n          <= 1'b0;
            strap_pin_out         <= 8'h00;
            strap_pin_oe          <= 1'b0;
            cfg_error             <= 1'b0;
            done_reg              <= 1'b0;
        end else begin
            src_is_bus_clk        <= cfg_reg.host_is_agent; // see R1
            sys_pll_mult          <= cfg_reg.mult; // see R2
            sys_pll_rst_n         <= st_reg != SCRC_S_WAIT; // see R2
            core_pll_setting      <= core_reg;
            core_pll_rst_n        <= st_reg != SCRC_S_WAIT && sys_lock_s; // see R8
            comms_engine_pll_mult <= cem_reg;
            comms_engine_pll_div  <= ced_reg;
            ce_pll_rst_n          <= sampled || ce_pll_rst_n; // see R9
            strap_pin_out         <= pin_reg;
            strap_pin_oe          <= sampled || strap_pin_oe; // see R14
            cfg_error             <= cfg_error || (capture && !mult_ok);
            done_reg              <= running;
        end
    end

    // ----------------------------------------
    // pll checks
    // ----------------------------------------
    chk_err_sticky: assert property (cfg_error |=> cfg_error) // see R2
        else $error("configuration error flag cleared");
    chk_err_hold: assert property (cfg_error |-> !sys_pll_rst_n && !core_pll_rst_n) // see R2
        else $error("pll released with reserved multiplier");
    chk_mult_copy: assert property (sys_pll_rst_n |-> sys_pll_mult == cfg_reg.mult) // see R2
        else $error("multiplier output differs from captured field");
    chk_src_follow: assert property ( // see R1
        sys_pll_rst_n |-> src_is_bus_clk == cfg_reg.host_is_agent)
        else $error("clock source differs from captured strap");
    chk_oe_sticky: assert property (strap_pin_oe |=> strap_pin_oe) // see R14
        else $error("strap pin driver released");
    chk_core_gate: assert property (!sys_lock_s |=> !core_pll_rst_n) // see R8
        else $error("core pll released without system lock");
    chk_core_after_sys: assert property (core_pll_rst_n |-> sys_pll_rst_n) // see R8
        else $error("core pll released ahead of system pll");

    // ----------------------------------------
    // derived clocks
    // ----------------------------------------
    logic       half_reg;
    logic [1:0] lb_cnt_reg;
    wire        base_tick = cfg_reg.lb_mode || half_reg; // see R5
    wire [1:0]  lb_thr = (lbr_reg == SCRC_LB_DIV2) ? 2'h0 :
                         (lbr_reg == SCRC_LB_DIV4) ? 2'h1 : 2'h3; // see R4
    always_ff @(posedge clock) begin
        if (!rst_n || !running) begin
            half_reg               <= 1'b0;
            lb_cnt_reg             <= 2'h0;
            local_bus_base_en      <= 1'b0;
            local_bus_output_clock <= 1'b0; // see R15
            mem_clk                <= 1'b0;
            mem_beat               <= 1'b0;
        end else begin
            half_reg          <= !half_reg;
            local_bus_base_en <= base_tick;
            if (base_tick) begin
                lb_cnt_reg <= (lb_cnt_reg >= lb_thr) ? 2'h0 : lb_cnt_reg + 2'h1;
                if (lb_cnt_reg >= lb_thr)
                    local_bus_output_clock <= !local_bus_output_clock; // see R4
            end
            mem_clk  <= !mem_clk;
            mem_beat <= 1'b1; // see R6
        end
    end

    // ----------------------------------------
    // clock checks
    // ----------------------------------------
    chk_base_full: assert property (running && cfg_reg.lb_mode |=> local_bus_base_en) // see R5
        else $error("base clock not at full rate");
    chk_lb_gate: assert property (!running |=> !local_bus_output_clock) // see R15
        else $error("local bus clock ran before lock");
    chk_beat_run: assert property (running |=> mem_beat) // see R6
        else $error("memory beat missing while running");
    chk_lb_steady: assert property ( // see R4
        running && !base_tick |=> $stable(local_bus_output_clock))
        else $error("local bus clock moved between base ticks");
    chk_base_gated: assert property (local_bus_base_en |-> $past(running)) // see R15
        else $error("base enable without running state");

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_src_select: assert property (done_reg |-> src_is_bus_clk == cfg_reg.host_is_agent) // see R1
        else $error("clock source does not follow agent strap");
    chk_mult_legal: assert property (sys_pll_rst_n |-> sys_pll_mult inside {[4'h2:4'h6]}) // see R2
        else $error("system pll released with reserved multiplier");
    chk_ratio_den: assert property (sampled && cfg_reg.in_div |-> ratio_den >= 4'h2) // see R3
        else $error("input divide strap ignored in ratio");
    chk_lb_toggle: assert property ($changed(local_bus_output_clock) && running
        |-> $past(base_tick)) // see R4
        else $error("local bus clock moved without base tick");
    chk_lb_half: assert property (running && !cfg_reg.lb_mode && local_bus_base_en
        ##1 running |-> !local_bus_base_en) // see R5
        else $error("base clock not halved");
    chk_mem_edges: assert property (mem_beat ##1 mem_beat |-> $changed(mem_clk)) // see R6
        else $error("memory beat without clock edge");
    chk_core_order: assert property ($rose(core_pll_rst_n) |-> $past(sys_lock_s)) // see R8
        else $error("core pll released before system lock");
    chk_ce_apart: assert property (sampled |=> ce_pll_rst_n) // see R9
        else $error("comms pll release held after sampling");
    chk_strap_dir: assert property (!sampled |-> ##1 !strap_pin_oe) // see R14
        else $error("strap pin driven before sampling");
    chk_clock_gate: assert property (!running |=> !mem_beat && !local_bus_base_en) // see R15
        else $error("derived clock ran before lock");
endmodule : scrc_top

/* File: sim/scrc_top_tb.sv */
// self-checking bench for the clock ratio configuration block
`include "scrc_map.svh"
module scrc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scrc_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, oe, src_bus, sys_rst_n, core_rst_n, ce_rst_n;
    logic        ce_div, lb_en, local_bus_base_clock, mem_clk, mem_beat, cfg_error;
    logic        sys_lock = 1'b0;
    logic        core_lock = 1'b0;
    logic        ce_lock = 1'b0;
    logic [7:0]  pin_out;
    logic [3:0]  mult, ce_mult;
    logic [6:0]  core_set;
    scrc_strap_t straps = 8'h04;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic        err;
    int          hp;
    always #10 clock = ~clock;
    scrc_top scrc_top_inst (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_pin_in(straps), .strap_pin_out(pin_out),
        .strap_pin_oe(oe), .sys_pll_lock(sys_lock), .core_pll_lock(core_lock),
        .ce_pll_lock(ce_lock), .src_is_bus_clk(src_bus), .sys_pll_mult(mult),
        .sys_pll_rst_n(sys_rst_n), .core_pll_setting(core_set), .core_pll_rst_n(core_rst_n),
        .comms_engine_pll_mult(ce_mult), .comms_engine_pll_div(ce_div),
        .ce_pll_rst_n(ce_rst_n), .local_bus_base_en(lb_en), .local_bus_output_clock(local_bus_base_clock),
        .mem_clk(mem_clk), .mem_beat(mem_beat), .cfg_error(cfg_error));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset(input scrc_strap_t s);
        rst_n  <= 1'b0;
        straps <= s;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : do_reset
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic half_per(output int n);
        logic v;
        int   k;
        k = 0;
        @(posedge clock);
        v = local_bus_base_clock;
        while (local_bus_base_clock === v && k < 40) begin
            @(posedge clock);
            k++;
        end
        v = local_bus_base_clock;
        n = 0;
        while (local_bus_base_clock === v && n < 40) begin
            @(posedge clock);
            n++;
        end
    endtask : half_per
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_host_bringup;
        logic mc;
        do_reset(8'h14);
        check("src", src_bus, 0);
        check("mult", mult, 4);
        check("oe", oe, 1);
        check("core_rst", core_rst_n, 0);
        check("gated", lb_en, 0);
        check("core_set", core_set, `SCRC_CORE_RST);
        sys_lock <= 1'b1;
        repeat (6) @(posedge clock);
        check("core_rst", core_rst_n, 1);
        core_lock <= 1'b1;
        repeat (10) @(posedge clock);
        check("base_en", lb_en, 1);
        @(posedge clock);
        check("base_en", lb_en, 1);
        check("beat", mem_beat, 1);
        mc = mem_clk;
        @(posedge clock);
        check("memclk", mem_clk, !mc);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `SCRC_OFF_LBR, i);
            half_per(hp);
            check("lb_half", hp, 1 << i);
        end
        apb(1'b0, `SCRC_OFF_STAT, 0);
        check("ratio", rd[15:8], 8'h24);
        sys_lock <= 1'b0;
        repeat (6) @(posedge clock);
        check("gated", lb_en, 0);
        check("core_rst", core_rst_n, 0);
    endtask : t_host_bringup
    task automatic t_agent_slow;
        sys_lock <= 1'b1;
        core_lock <= 1'b1;
        do_reset(8'hE6);
        repeat (12) @(posedge clock);
        check("src", src_bus, 1);
        half_per(hp);
        check("lb_half", hp, 2);
        apb(1'b0, `SCRC_OFF_STAT, 0);
        check("ratio", rd[15:8], 8'h46);
        apb(1'b1, `SCRC_OFF_CEC, 32'h13);
        apb(1'b1, `SCRC_OFF_CORE, 32'h05);
        repeat (2) @(posedge clock);
        check("ce", {ce_div, ce_mult}, 5'h13);
        check("core_set", core_set, 7'h05);
        straps <= 8'h03;
        repeat (8) @(posedge clock);
        check("mult", mult, 6);
        apb(1'b1, `SCRC_OFF_PIN, 32'hA5);
        repeat (2) @(posedge clock);
        check("pin", pin_out, 8'hA5);
        apb(1'b0, `SCRC_OFF_CFG, 0);
        check("cfg", rd, 32'hE6);
        apb(1'b0, 8'h18, 0);
        check("unmapped_err", err, 1'b1);
        check("unmapped_rd", rd, 32'h00000000);
    endtask : t_agent_slow
    task automatic t_codes;
        sys_lock <= 1'b0;
        core_lock <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            do_reset(c[7:0]);
            check("sys_rst", sys_rst_n, c >= 2 && c <= 6);
            check("cfg_err", cfg_error, c < 2 || c > 6);
            check("ce_rst", ce_rst_n, 1);
        end
    endtask : t_codes
    initial begin
        t_host_bringup();
        t_agent_slow();
        t_codes();
        tally_and_finish();
    end
endmodule : scrc_top_tb
